// ### include/pioc_pkg.sv
// Constants for the port pin control block: register indices, field
// positions, reset values and pin assignments.
// Assumes a 32-bit AXI4-Lite register bus; byte address = index * 4.
package pioc_pkg;

  // ----------------------------------------------------------------
  // Pin layout
  // ----------------------------------------------------------------
  localparam int NPIN = 15;
  localparam int P0_W = 8;
  localparam int P2_W = 6;
  localparam int P3_W = 1;
  localparam int P2_LSB = 8;
  localparam int P3_LSB = 14;
  localparam int PIN_INVERTED_CORE_CLOCK_OUT = 0;
  localparam int PIN_XCLK = 3;
  localparam int PIN_TX = 4;
  localparam int PIN_RX = 5;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_P0 = 8'h80;
  localparam logic [7:0] IDX_P2 = 8'hA0;
  localparam logic [7:0] IDX_P3 = 8'hB0;
  localparam logic [7:0] IDX_GPIO_CTL = 8'hE2;
  localparam logic [7:0] IDX_P0_MODE = 8'hA4;
  localparam logic [7:0] IDX_P2_MODE = 8'hA6;
  localparam logic [7:0] IDX_P3_MODE = 8'hA7;
  localparam logic [7:0] IDX_P0_VIEW = 8'hC0;
  localparam logic [7:0] IDX_P2_VIEW = 8'hC1;
  localparam logic [7:0] IDX_P3_VIEW = 8'hC2;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTL_WEAK_BIT = 7;
  localparam int CTL_INEN_BIT = 6;
  localparam int CTL_INVERTED_CORE_CLOCK_OUT_BIT = 0;
  localparam logic [7:0] CTL_RESET = 8'h40;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pioc_pkg

// ### logic/pioc_pin_cell.sv
// One port pin cell: registered driver and pullup controls.
// Assumes drive already combines the latch with any special signal.
`timescale 1ns/1ps
`default_nettype none
module pioc_pin_cell (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic latch,
  input wire logic drive,
  input wire logic mode,
  input wire logic weak_pullup_disable,
  output logic pin_out,
  output logic pin_oe,
  output logic pullup_en
);

  // ----------------------------------------------------------------
  // Driver decode
  // ----------------------------------------------------------------
  // Open-drain only ever pulls low; a high drive releases the pin.
  wire next_out = mode & drive;
  wire next_oe = mode | ~drive;
  // Pullup only on an open-drain pin whose latch is 1, to avoid burning power.
  wire next_pu = ~weak_pullup_disable & ~mode & latch;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pullup_en <= 1'b0;
    end else if (ce) begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      pullup_en <= next_pu;
    end
  end

endmodule : pioc_pin_cell
`default_nettype wire

// ### logic/pioc_port_io.sv
// Port pin control: latches, output modes, global control and
// special signal routing for 15 pins, behind an AXI4-Lite slave.
// Assumes pins are asynchronous to clk_sys; uart_tx_out is on clk_sys.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Fifteen pins, each general purpose, some carrying special signals.
// - Open-drain: low driver on for latch 0, pin floats for latch 1.
// - Push-pull: exactly one driver on, pin follows the latch.
// - Pullup only when enabled globally, open-drain and latch 1.
// - Port read returns sensed pin levels, never the latch.
// - Inverted core clock drives port0_bit0 when routing bit is set.
// - External clock input always comes from port0_bit3.
// - UART transmit goes to port0_bit4, ANDed with its latch.
// - Idle UART transmit stays 1; software keeps that latch at 1.
// - Without global input enable, pins sense nothing.
// - Port reads give pin levels with inputs enabled, else zero.
// - Read-modify-write reads the latch, not the pin.
module pioc_port_io (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [pioc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pioc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pioc_pkg::NPIN-1:0] pin_in,
  output logic [pioc_pkg::NPIN-1:0] pin_out,
  output logic [pioc_pkg::NPIN-1:0] pin_oe,
  output logic [pioc_pkg::NPIN-1:0] pin_pullup_en,
  input wire logic uart_tx_out,
  output logic uart_rx_in,
  output logic ext_clock_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [pioc_pkg::P0_W-1:0] p0_latch;
  logic [pioc_pkg::P2_W-1:0] p2_latch;
  logic [pioc_pkg::P3_W-1:0] p3_latch;
  logic [pioc_pkg::P0_W-1:0] p0_mode;
  logic [pioc_pkg::P2_W-1:0] p2_mode;
  logic [pioc_pkg::P3_W-1:0] p3_mode;
  logic [7:0] gpio_ctl;
  logic [pioc_pkg::NPIN-1:0] pin_s1;
  logic [pioc_pkg::NPIN-1:0] pin_s2;
  logic [pioc_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic [pioc_pkg::NPIN-1:0] cell_out;
  logic [pioc_pkg::NPIN-1:0] cell_oe;

  function automatic logic hit(input logic [pioc_pkg::ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {idx, 2'h0});
  endfunction : hit

  // ----------------------------------------------------------------
  // Control fields and pin vectors
  // ----------------------------------------------------------------
  wire weak_pullup_disable = gpio_ctl[pioc_pkg::CTL_WEAK_BIT];
  wire global_input_enable = gpio_ctl[pioc_pkg::CTL_INEN_BIT];
  wire inverted_core_clock_out_route = gpio_ctl[pioc_pkg::CTL_INVERTED_CORE_CLOCK_OUT_BIT];
  wire [pioc_pkg::NPIN-1:0] latch_all = {p3_latch, p2_latch, p0_latch};
  wire [pioc_pkg::NPIN-1:0] mode_all = {p3_mode, p2_mode, p0_mode};
  // Transmit is gated by its own latch, so a 0 there forces the pin low
  wire tx_gated = latch_all[pioc_pkg::PIN_TX] & uart_tx_out;
  wire [pioc_pkg::NPIN-1:0] tx_mask = pioc_pkg::NPIN'(1) << pioc_pkg::PIN_TX;
  wire [pioc_pkg::NPIN-1:0] drive_all =
    (latch_all & ~tx_mask) | ({pioc_pkg::NPIN{tx_gated}} & tx_mask);
  // Inputs are blocked entirely until the global enable is set
  wire [pioc_pkg::NPIN-1:0] sensed =
    global_input_enable ? pin_s2 : '0;

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < pioc_pkg::NPIN; gi++) begin : g_cell
      pioc_pin_cell u_cell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .latch(latch_all[gi]),
        .drive(drive_all[gi]),
        .mode(mode_all[gi]),
        .weak_pullup_disable(weak_pullup_disable),
        .pin_out(cell_out[gi]),
        .pin_oe(cell_oe[gi]),
        .pullup_en(pin_pullup_en[gi])
      );
    end
  endgenerate

  // The clock itself cannot pass a flop; this one bit is a plain mux.
  assign pin_out = {cell_out[pioc_pkg::NPIN-1:1],
                    inverted_core_clock_out_route ? ~clk_sys : cell_out[0]};
  assign pin_oe = {cell_oe[pioc_pkg::NPIN-1:1],
                   inverted_core_clock_out_route | cell_oe[0]};

  // ----------------------------------------------------------------
  // Input synchronisers and special inputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      uart_rx_in <= 1'b1;
      ext_clock_in <= 1'b0;
    end else if (ce) begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      // Receive idles high while blocked so no false start bit shows
      uart_rx_in <= ~global_input_enable |
                    pin_s2[pioc_pkg::PIN_RX];
      ext_clock_in <= sensed[pioc_pkg::PIN_XCLK];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_do = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_en = wr_do & w_lane0;
  wire wh_p0 = hit(aw_addr, pioc_pkg::IDX_P0);
  wire wh_p2 = hit(aw_addr, pioc_pkg::IDX_P2);
  wire wh_p3 = hit(aw_addr, pioc_pkg::IDX_P3);
  wire wh_m0 = hit(aw_addr, pioc_pkg::IDX_P0_MODE);
  wire wh_m2 = hit(aw_addr, pioc_pkg::IDX_P2_MODE);
  wire wh_m3 = hit(aw_addr, pioc_pkg::IDX_P3_MODE);
  wire wh_ctl = hit(aw_addr, pioc_pkg::IDX_GPIO_CTL);
  wire wh_view = hit(aw_addr, pioc_pkg::IDX_P0_VIEW) |
                 hit(aw_addr, pioc_pkg::IDX_P2_VIEW) |
                 hit(aw_addr, pioc_pkg::IDX_P3_VIEW);
  wire w_mapped = wh_p0 | wh_p2 | wh_p3 | wh_m0 | wh_m2 | wh_m3 |
                  wh_ctl | wh_view;
  // Only the three live control bits are stored; the rest read zero
  wire [7:0] ctl_mask = 8'h1 << pioc_pkg::CTL_WEAK_BIT |
                        8'h1 << pioc_pkg::CTL_INEN_BIT |
                        8'h1 << pioc_pkg::CTL_INVERTED_CORE_CLOCK_OUT_BIT;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pioc_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_byte <= '0;
      w_lane0 <= 1'b0;
    end else if (ce) begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? pioc_pkg::RESP_OKAY
                                : pioc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p0_latch <= pioc_pkg::LATCH_RESET[pioc_pkg::P0_W-1:0];
      p2_latch <= pioc_pkg::LATCH_RESET[pioc_pkg::P2_W-1:0];
      p3_latch <= pioc_pkg::LATCH_RESET[pioc_pkg::P3_W-1:0];
      p0_mode <= pioc_pkg::MODE_RESET[pioc_pkg::P0_W-1:0];
      p2_mode <= pioc_pkg::MODE_RESET[pioc_pkg::P2_W-1:0];
      p3_mode <= pioc_pkg::MODE_RESET[pioc_pkg::P3_W-1:0];
      gpio_ctl <= pioc_pkg::CTL_RESET;
    end else if (ce & wr_en) begin
      // The write lands on the edge that raises s_axi_bvalid, one before the response closes
      if (wh_p0) p0_latch <= w_byte[pioc_pkg::P0_W-1:0];
      if (wh_p2) p2_latch <= w_byte[pioc_pkg::P2_W-1:0];
      if (wh_p3) p3_latch <= w_byte[pioc_pkg::P3_W-1:0];
      if (wh_m0) p0_mode <= w_byte[pioc_pkg::P0_W-1:0];
      if (wh_m2) p2_mode <= w_byte[pioc_pkg::P2_W-1:0];
      if (wh_m3) p3_mode <= w_byte[pioc_pkg::P3_W-1:0];
      if (wh_ctl) gpio_ctl <= w_byte & ctl_mask;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rh_p0 = hit(s_axi_araddr, pioc_pkg::IDX_P0);
  wire rh_p2 = hit(s_axi_araddr, pioc_pkg::IDX_P2);
  wire rh_p3 = hit(s_axi_araddr, pioc_pkg::IDX_P3);
  wire rh_m0 = hit(s_axi_araddr, pioc_pkg::IDX_P0_MODE);
  wire rh_m2 = hit(s_axi_araddr, pioc_pkg::IDX_P2_MODE);
  wire rh_m3 = hit(s_axi_araddr, pioc_pkg::IDX_P3_MODE);
  wire rh_ctl = hit(s_axi_araddr, pioc_pkg::IDX_GPIO_CTL);
  wire rh_v0 = hit(s_axi_araddr, pioc_pkg::IDX_P0_VIEW);
  wire rh_v2 = hit(s_axi_araddr, pioc_pkg::IDX_P2_VIEW);
  wire rh_v3 = hit(s_axi_araddr, pioc_pkg::IDX_P3_VIEW);
  wire r_mapped = rh_p0 | rh_p2 | rh_p3 | rh_m0 | rh_m2 | rh_m3 |
                  rh_ctl | rh_v0 | rh_v2 | rh_v3;
  // Port reads give the pins; the view registers give the latch so
  // that software can modify and write back without pin loading.
  wire [7:0] rd_byte =
    rh_p0 ? 8'(sensed[pioc_pkg::P0_W-1:0]) :
    rh_p2 ? 8'(sensed[pioc_pkg::P3_LSB-1:pioc_pkg::P2_LSB]) :
    rh_p3 ? 8'(sensed[pioc_pkg::P3_LSB]) :
    rh_m0 ? 8'(p0_mode) :
    rh_m2 ? 8'(p2_mode) :
    rh_m3 ? 8'(p3_mode) :
    rh_ctl ? gpio_ctl :
    rh_v0 ? 8'(p0_latch) :
    rh_v2 ? 8'(p2_latch) :
    rh_v3 ? 8'(p3_latch) : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pioc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= r_mapped ? pioc_pkg::RESP_OKAY
                                : pioc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Pipelined checks need rst_n sampled high as well: at the edge that
  // releases reset the flops still load their reset values.
  wire pu_want2 = ~weak_pullup_disable & ~mode_all[2] & latch_all[2];
  wire xclk_want = global_input_enable & pin_s2[pioc_pkg::PIN_XCLK];

  od_drive_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rst_n && ce && !mode_all[2] |=>
      pin_oe[2] == !$past(latch_all[2]) && !pin_out[2])
    else $error("open-drain driver wrong");

  pp_drive_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rst_n && ce && mode_all[2] |=>
      pin_oe[2] && pin_out[2] == $past(latch_all[2]))
    else $error("push-pull driver wrong");

  pullup_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rst_n && ce |=> pin_pullup_en[2] == $past(pu_want2))
    else $error("weak pullup wrong");

  tx_and_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rst_n && ce && mode_all[pioc_pkg::PIN_TX] |=>
      pin_out[pioc_pkg::PIN_TX] == $past(tx_gated))
    else $error("transmit gating wrong");

  rd_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && ar_take && rh_p0 && !global_input_enable |=>
      s_axi_rvalid && s_axi_rdata == 32'h00000000)
    else $error("blocked port read not zero");

  rx_block_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && !global_input_enable |=> uart_rx_in)
    else $error("receive not blocked");

  xclk_route_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rst_n && ce |=> ext_clock_in == $past(xclk_want))
    else $error("external clock routing wrong");

  wr_latch_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && wr_en && wh_p0 |=> p0_latch == $past(w_byte))
    else $error("latch write not taken");

  latch_view_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && ar_take && rh_v0 |=> s_axi_rdata[7:0] == $past(p0_latch))
    else $error("latch view wrong");

  write_done_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bready && s_axi_bresp == pioc_pkg::RESP_OKAY);
  inverted_core_clock_out_on_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n) inverted_core_clock_out_route);
  input_read_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    ar_take && rh_p0 && global_input_enable ##1 s_axi_rdata != 32'h0);
  tx_forced_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    mode_all[pioc_pkg::PIN_TX] && !tx_gated);
  bad_read_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rresp == pioc_pkg::RESP_SLVERR);

endmodule : pioc_port_io
`default_nettype wire

// ### verification/pioc_pin_model.sv
// Board-side model of the fifteen port pins: drivers, pullups, floating.
// Assumes pin controls come from the port block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pioc_pin_model (
  input wire logic clk_sys,
  input wire logic [pioc_pkg::NPIN-1:0] pin_out,
  input wire logic [pioc_pkg::NPIN-1:0] pin_oe,
  input wire logic [pioc_pkg::NPIN-1:0] pin_pullup_en,
  input wire logic [pioc_pkg::NPIN-1:0] drv_val,
  input wire logic [pioc_pkg::NPIN-1:0] drv_en,
  output logic [pioc_pkg::NPIN-1:0] pin_in
);
  // A floating pin toggles each cycle so no stale level reads back
  logic flip;
  initial flip = 1'b0;
  always @(posedge clk_sys) flip <= ~flip;
  always_comb begin
    for (int i = 0; i < pioc_pkg::NPIN; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (drv_en[i])
        pin_in[i] = drv_val[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = flip;
    end
  end
endmodule : pioc_pin_model
`default_nettype wire

// ### verification/pioc_port_io_tb.sv
// Self-checking bench for the port pin control block.
// Assumes pioc_pkg and the board model pioc_pin_model.
`timescale 1ns/1ps
`default_nettype none
module pioc_port_io_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, uart_tx = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [9:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, uart_rx, ext_clk;
  logic [1:0] bresp, rresp, rs;
  logic [14:0] pin_in, pin_out, pin_oe, pull, drv_val = '0, drv_en = '0;
  int num_errors = 0, n_compared = 0, cycles = 0;

  always #20 clk_sys = ~clk_sys;

  pioc_port_io i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pull), .uart_tx_out(uart_tx),
    .uart_rx_in(uart_rx), .ext_clock_in(ext_clk));

  pioc_pin_model i_pins (.clk_sys(clk_sys), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pull), .drv_val(drv_val),
    .drv_en(drv_en), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] st = 4'hF);
    @(posedge clk_sys);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdreg(input logic [7:0] idx);
    @(posedge clk_sys);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rdreg

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    rdreg(idx);
    chk(rd, {24'h000000, exp});
  endtask : rchk

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    cyc(2);
    chk(pin_oe, 32'h0);
    chk(pull, 32'h7FFF);
    rchk(pioc_pkg::IDX_GPIO_CTL, pioc_pkg::CTL_RESET);
    rchk(pioc_pkg::IDX_P0_VIEW, pioc_pkg::LATCH_RESET);
    rchk(pioc_pkg::IDX_P0, 8'hFF);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_drive;
    logic [7:0] lt, md;
    lt = 8'hA5;
    md = 8'h0F;
    wr(pioc_pkg::IDX_P0_MODE, md);
    wr(pioc_pkg::IDX_P0, lt);
    // Pins follow the flops one edge after the storing edge
    #1;
    chk(pin_oe[7:0], 8'(md | ~lt));
    chk(pin_out[7:0] & pin_oe[7:0], 8'(md & lt));
    chk(pull[7:0], 8'(~md & lt));
    wr(pioc_pkg::IDX_GPIO_CTL, 8'hC0);
    cyc(2);
    chk(pull, 32'h0);
    wr(pioc_pkg::IDX_GPIO_CTL, 8'h40);
    wr(pioc_pkg::IDX_P0, 8'hFF);
    wr(pioc_pkg::IDX_P0_MODE, 8'h00);
    $display("t_drive done");
  endtask : t_drive

  task automatic t_read;
    wr(pioc_pkg::IDX_P2, 8'h3E);
    drv_en <= 15'h3E00;
    drv_val <= 15'h1508;
    cyc(3);
    rchk(pioc_pkg::IDX_P2, 8'h14);
    rchk(pioc_pkg::IDX_P2_VIEW, 8'h3E);
    rdreg(pioc_pkg::IDX_P2_VIEW);
    wr(pioc_pkg::IDX_P2, rd[7:0] | 8'h01);
    rchk(pioc_pkg::IDX_P2_VIEW, 8'h3F);
    wr(pioc_pkg::IDX_GPIO_CTL, 8'h00);
    drv_en <= 15'h0028;
    cyc(4);
    rchk(pioc_pkg::IDX_P2, 8'h00);
    rchk(pioc_pkg::IDX_P0, 8'h00);
    chk(ext_clk, 32'h0);
    chk(uart_rx, 32'h1);
    wr(pioc_pkg::IDX_GPIO_CTL, 8'h40);
    cyc(4);
    chk({ext_clk, uart_rx}, 32'h2);
    drv_val <= 15'h0020;
    cyc(4);
    chk({ext_clk, uart_rx}, 32'h1);
    $display("t_read done");
  endtask : t_read

  task automatic t_special;
    wr(pioc_pkg::IDX_P0_MODE, 8'h10);
    for (int k = 0; k < 4; k++) begin
      uart_tx <= k[0];
      wr(pioc_pkg::IDX_P0, {3'b111, k[1], 4'hF});
      cyc(2);
      chk({pin_oe[4], pin_out[4]}, {1'b1, k[0] & k[1]});
    end
    uart_tx <= 1'b1;
    wr(pioc_pkg::IDX_GPIO_CTL, 8'h41);
    cyc(2);
    #10;
    chk({pin_oe[0], pin_out[0]}, 32'h2);
    #20;
    chk({pin_oe[0], pin_out[0]}, 32'h3);
    wr(pioc_pkg::IDX_GPIO_CTL, 8'h40);
    cyc(2);
    chk(pin_oe[0], 32'h0);
    $display("t_special done");
  endtask : t_special

  task automatic t_bus;
    wr(8'h00, 8'h55);
    chk(rs, pioc_pkg::RESP_SLVERR);
    rdreg(8'h00);
    chk(rs, pioc_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    wr(pioc_pkg::IDX_P0, 8'h00, 4'h0);
    chk(rs, pioc_pkg::RESP_OKAY);
    rchk(pioc_pkg::IDX_P0_VIEW, 8'hFF);
    wr(pioc_pkg::IDX_GPIO_CTL, 8'hFF);
    rchk(pioc_pkg::IDX_GPIO_CTL, 8'hC1);
    wr(pioc_pkg::IDX_GPIO_CTL, 8'h40);
    $display("t_bus done");
  endtask : t_bus

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude;
    end
  end

  initial begin
    cyc(3);
    rst_n <= 1'b1;
    t_reset;
    t_drive;
    t_read;
    t_special;
    t_bus;
    conclude;
  end
endmodule : pioc_port_io_tb
`default_nettype wire
